/* design/fan_ctrl_pkg.sv */
package fan_ctrl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_KHZ = 125_000;
	localparam int unsigned RESET_PULSE_MIN_NS = 125_000;
	// Least time, rounded up to whole cycles
	localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_MIN_NS * (CLK_KHZ / 1000) + 999) / 1000;
	localparam int unsigned RAMP_BASE_HZ = 16;
	localparam int unsigned RAMP_BASE_CYCLES = (CLK_KHZ * 1000) / RAMP_BASE_HZ;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_REMOTE_FUNC = 8'h4B;
	localparam logic [7:0] OFS_ALERT_LEVEL = 8'h4C;
	localparam logic [7:0] OFS_FAN_RAMP = 8'hC0;
	localparam logic [7:0] OFS_FAN_SPEED = 8'hC1;

	localparam int unsigned RF_RESET_BIT = 0;
	localparam int unsigned RF_OFF_BIT = 1;
	localparam int unsigned AL_EXT_BIT = 0;
	localparam int unsigned AL_GPI_BIT = 1;
	localparam int unsigned AL_INT_BIT = 2;
	localparam int unsigned RAMP_EN_BIT = 0;
	localparam int unsigned RAMP_RATE_LSB = 1;
	localparam int unsigned RAMP_RATE_MSB = 2;

	localparam logic [7:0] REMOTE_FUNC_RESET = 8'h00;
	localparam logic [7:0] FAN_RAMP_RESET = 8'h00;
	localparam logic [7:0] FAN_SPEED_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_1HZ = 2'h0,
		RATE_4HZ = 2'h1,
		RATE_8HZ = 2'h2,
		RATE_16HZ = 2'h3
	} ramp_rate_t;

	typedef enum logic [1:0] {
		PULSE_IDLE = 2'h1,
		PULSE_LOW = 2'h2
	} pulse_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic external_overtemp_live;
		logic internal_overtemp_live;
	} alert_live_t;

endpackage

/* design/ramp_tick_gen.sv */
`timescale 1ns/1ps
module ramp_tick_gen #(
	parameter int unsigned BASE_CYCLES = fan_ctrl_pkg::RAMP_BASE_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire fan_ctrl_pkg::ramp_rate_t rate_i,
	output logic tick_o
);

	localparam int unsigned PW = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;
	localparam logic [PW-1:0] PRESC_LAST = PW'(BASE_CYCLES - 1);

	if (BASE_CYCLES < 2) begin : g_chk
		$error("BASE_CYCLES must be at least 2");
	end

	typedef struct packed {
		logic [PW-1:0] presc;
		logic [3:0] sub;
		logic tick;
	} tick_state_t;

	tick_state_t s_q, s_d;
	logic [3:0] mask;

	// ----------------------------------------------------------------
	// Base 16 Hz prescaler, divided down by the selected rate
	// ----------------------------------------------------------------
	always_comb begin
		unique case (rate_i)
			fan_ctrl_pkg::RATE_16HZ: mask = 4'h0;
			fan_ctrl_pkg::RATE_8HZ: mask = 4'h1;
			fan_ctrl_pkg::RATE_4HZ: mask = 4'h3;
			fan_ctrl_pkg::RATE_1HZ: mask = 4'hF;
		endcase
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.presc == PRESC_LAST) begin
			s_d.presc = '0;
			s_d.sub = s_q.sub + 4'h1;
			s_d.tick = ((s_q.sub & mask) == mask);
		end else begin
			s_d.presc = s_q.presc + PW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;

	a_tick_on_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tick_o |-> $past(s_q.presc) == PRESC_LAST)
		else $error("ramp tick outside prescaler wrap");

endmodule // ramp_tick_gen

/* design/remote_ctrl_alert_fan_ramp.sv */
`timescale 1ns/1ps
module remote_ctrl_alert_fan_ramp #(
	parameter int unsigned PULSE_CYCLES = fan_ctrl_pkg::RESET_PULSE_CYCLES,
	parameter int unsigned RAMP_BASE_CYCLES = fan_ctrl_pkg::RAMP_BASE_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire fan_ctrl_pkg::reg_req_t req_i,
	input wire logic general_purpose_input_i,
	input wire logic input_polarity_invert_i,
	input wire fan_ctrl_pkg::alert_live_t live_i,
	output logic [7:0] rd_data_o,
	output logic remote_reset_n_o,
	output logic remote_off_o,
	output logic [7:0] dac_code_o
);

	localparam int unsigned CW = (PULSE_CYCLES > 1) ? $clog2(PULSE_CYCLES) : 1;
	localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYCLES - 1);

	if (PULSE_CYCLES < 1) begin : g_chk
		$error("PULSE_CYCLES must be at least 1");
	end

	typedef struct packed {
		logic rst_bit;
		logic off_bit;
		logic [5:0] rf_rsvd;
		fan_ctrl_pkg::pulse_state_t pulse;
		logic [CW-1:0] pulse_cnt;
		logic reset_n;
		logic [7:0] ramp;
		logic [7:0] target;
		logic [7:0] dac;
		logic [7:0] rd_data;
		logic gpi_meta;
		logic gpi_sync;
	} ctrl_state_t;

	ctrl_state_t s_q, s_d;
	logic tick;
	logic ramp_en;
	logic wr_rf, wr_ramp, wr_fan, rd_any;
	logic [7:0] alert_now;
	logic [7:0] rf_now;

	// ----------------------------------------------------------------
	// Ramp tick source
	// ----------------------------------------------------------------
	ramp_tick_gen #(
		.BASE_CYCLES(RAMP_BASE_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.rate_i(fan_ctrl_pkg::ramp_rate_t'(
			s_q.ramp[fan_ctrl_pkg::RAMP_RATE_MSB:fan_ctrl_pkg::RAMP_RATE_LSB])),
		.tick_o(tick)
	);

	// ----------------------------------------------------------------
	// Decode and read views
	// ----------------------------------------------------------------
	always_comb begin
		wr_rf = req_i.wr && (req_i.addr == fan_ctrl_pkg::OFS_REMOTE_FUNC);
		wr_ramp = req_i.wr && (req_i.addr == fan_ctrl_pkg::OFS_FAN_RAMP);
		wr_fan = req_i.wr && (req_i.addr == fan_ctrl_pkg::OFS_FAN_SPEED);
		rd_any = req_i.rd;
		ramp_en = s_q.ramp[fan_ctrl_pkg::RAMP_EN_BIT];
		alert_now = fan_ctrl_pkg::READ_NONE;
		alert_now[fan_ctrl_pkg::AL_EXT_BIT] = live_i.external_overtemp_live;
		alert_now[fan_ctrl_pkg::AL_INT_BIT] = live_i.internal_overtemp_live;
		alert_now[fan_ctrl_pkg::AL_GPI_BIT] = s_q.gpi_sync ^ input_polarity_invert_i;
		rf_now = {s_q.rf_rsvd, s_q.off_bit, s_q.rst_bit};
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.gpi_meta = general_purpose_input_i;
		s_d.gpi_sync = s_q.gpi_meta;

		if (rd_any) begin
			unique case (req_i.addr)
				fan_ctrl_pkg::OFS_REMOTE_FUNC: s_d.rd_data = rf_now;
				fan_ctrl_pkg::OFS_ALERT_LEVEL: s_d.rd_data = alert_now;
				fan_ctrl_pkg::OFS_FAN_RAMP: s_d.rd_data = s_q.ramp;
				fan_ctrl_pkg::OFS_FAN_SPEED: s_d.rd_data = s_q.target;
				default: s_d.rd_data = fan_ctrl_pkg::READ_NONE;
			endcase
		end

		// Remote function register: ones in bits 1:0 act (bit 0 only while no pulse runs), zeros there are ignored; bits 7:2 are stored as written
		if (wr_rf) begin
			s_d.rf_rsvd = req_i.wdata[7:2];
			if (req_i.wdata[fan_ctrl_pkg::RF_OFF_BIT]) begin
				s_d.off_bit = 1'b1;
			end
		end

		unique case (s_q.pulse)
			fan_ctrl_pkg::PULSE_IDLE: begin
				if (wr_rf && req_i.wdata[fan_ctrl_pkg::RF_RESET_BIT]) begin
					s_d.rst_bit = 1'b1;
					s_d.reset_n = 1'b0;
					s_d.pulse_cnt = '0;
					s_d.pulse = fan_ctrl_pkg::PULSE_LOW;
				end
			end
			fan_ctrl_pkg::PULSE_LOW: begin
				if (s_q.pulse_cnt == PULSE_LAST) begin
					s_d.rst_bit = 1'b0;
					s_d.reset_n = 1'b1;
					s_d.pulse = fan_ctrl_pkg::PULSE_IDLE;
				end else begin
					s_d.pulse_cnt = s_q.pulse_cnt + CW'(1);
				end
			end
			default: begin
				s_d.rst_bit = 1'b0;
				s_d.reset_n = 1'b1;
				s_d.pulse = fan_ctrl_pkg::PULSE_IDLE;
			end
		endcase

		if (wr_ramp) begin
			s_d.ramp = req_i.wdata;
		end

		// Fan speed: target always; DAC at once only with ramping off
		if (wr_fan) begin
			s_d.target = req_i.wdata;
			if (!ramp_en) begin
				s_d.dac = req_i.wdata;
			end
		end else if (ramp_en && tick && (s_q.dac != s_q.target)) begin
			if (s_q.dac < s_q.target) begin
				s_d.dac = s_q.dac + 8'h01;
			end else begin
				s_d.dac = s_q.dac - 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
			s_q.pulse <= fan_ctrl_pkg::PULSE_IDLE;
			s_q.reset_n <= 1'b1;
			s_q.ramp <= fan_ctrl_pkg::FAN_RAMP_RESET;
			s_q.target <= fan_ctrl_pkg::FAN_SPEED_RESET;
			s_q.dac <= fan_ctrl_pkg::FAN_SPEED_RESET;
			s_q.rf_rsvd <= fan_ctrl_pkg::REMOTE_FUNC_RESET[7:2];
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_o = s_q.rd_data;
	assign remote_reset_n_o = s_q.reset_n;
	assign remote_off_o = s_q.off_bit;
	assign dac_code_o = s_q.dac;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	int unsigned low_run_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || remote_reset_n_o) begin
			low_run_q <= 0;
		end else begin
			low_run_q <= low_run_q + 1;
		end
	end

	sequence s_reset_req;
		wr_rf && req_i.wdata[fan_ctrl_pkg::RF_RESET_BIT] && remote_reset_n_o;
	endsequence

	sequence s_reset_low;
		!remote_reset_n_o && s_q.rst_bit;
	endsequence

	a_pulse_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_reset_req |=> s_reset_low)
		else $error("reset pulse did not start");

	a_pulse_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(remote_reset_n_o) |-> low_run_q == PULSE_CYCLES)
		else $error("reset pulse length wrong");

	a_bit_selfclear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_q.rst_bit == !remote_reset_n_o)
		else $error("reset bit not tied to pulse");

	a_zero_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_rf && req_i.wdata[1:0] == 2'h0) |=>
		$stable(remote_off_o) && (remote_reset_n_o || !$past(remote_reset_n_o)))
		else $error("zero write changed a control output");

	a_read_stored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_any && req_i.addr == fan_ctrl_pkg::OFS_REMOTE_FUNC) |=>
		rd_data_o[1:0] == {$past(s_q.off_bit), $past(s_q.rst_bit)})
		else $error("remote function read wrong");

	a_off_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_rf && req_i.wdata[fan_ctrl_pkg::RF_OFF_BIT]) ##1 1'b1 |-> remote_off_o [*2])
		else $error("power-off output not held high");

	a_off_reset: assert property (@(posedge clk_i)
		!rst_n_i |=> !remote_off_o && remote_reset_n_o && !s_q.rst_bit)
		else $error("reset did not clear remote controls");

	a_alert_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_any && req_i.addr == fan_ctrl_pkg::OFS_ALERT_LEVEL) |=>
		rd_data_o == {5'h00, $past(live_i.internal_overtemp_live),
		$past(s_q.gpi_sync) ^ $past(input_polarity_invert_i),
		$past(live_i.external_overtemp_live)})
		else $error("alert level read wrong");

	a_direct_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_fan && !ramp_en) |=> dac_code_o == $past(req_i.wdata))
		else $error("direct fan write not applied");

	a_ramp_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ramp_en && tick && !wr_fan && s_q.dac < s_q.target) |=>
		dac_code_o == $past(s_q.dac) + 8'h01)
		else $error("ramp up step wrong");

	a_ramp_step_down: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ramp_en && tick && !wr_fan && s_q.dac > s_q.target) |=>
		dac_code_o == $past(s_q.dac) - 8'h01)
		else $error("ramp down step wrong");

	a_target_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_fan && ramp_en) |=> $stable(dac_code_o))
		else $error("ramped fan write moved the DAC");

	a_ramp_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ramp_en && !wr_fan && (!tick || s_q.dac == s_q.target)) |=> $stable(dac_code_o))
		else $error("DAC moved without a tick");

endmodule // remote_ctrl_alert_fan_ramp

/* bench/smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model (
	input wire logic clk_i,
	output fan_ctrl_pkg::reg_req_t req_o
);

	initial req_o = '0;

	// ----------------------------------------------------------------
	// One register access, held across one sampling edge
	// ----------------------------------------------------------------
	// This host drives each access as given and never looks at ramp enable
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

endmodule // smbus_host_model

/* bench/test_remote_ctrl_alert_fan_ramp.sv */
`timescale 1ns/1ps
module test_remote_ctrl_alert_fan_ramp;

	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	fan_ctrl_pkg::reg_req_t req;
	logic general_purpose_input = 1'b0;
	logic inv = 1'b0;
	fan_ctrl_pkg::alert_live_t live = '0;
	logic [7:0] rd_data;
	logic reset_n;
	logic off;
	logic [7:0] dac;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;

	remote_ctrl_alert_fan_ramp #(.PULSE_CYCLES(8), .RAMP_BASE_CYCLES(4)) uut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.req_i(req),
		.general_purpose_input_i(general_purpose_input),
		.input_polarity_invert_i(inv),
		.live_i(live),
		.rd_data_o(rd_data),
		.remote_reset_n_o(reset_n),
		.remote_off_o(off),
		.dac_code_o(dac)
	);

	smbus_host_model host (
		.clk_i(clk_i),
		.req_o(req)
	);

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		host.access(1'b0, a, 8'h00);
		check(rd_data, exp);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(negedge clk_i);
		rst_n_i = 1'b0;
		repeat (8) @(negedge clk_i);
		rst_n_i = 1'b1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset_values();
		rd(8'h4B, 8'h00);
		rd(8'h4C, 8'h00);
		rd(8'hC0, 8'h00);
		rd(8'h10, 8'h00);
		$display("test reset values done");
	endtask

	task automatic test_pulse();
		int n;
		host.access(1'b1, 8'h4B, 8'h01);
		n = 0;
		while (reset_n !== 1'b1 && n < 100) begin
			n++;
			@(negedge clk_i);
		end
		check(8'(n), 8'h08);
		rd(8'h4B, 8'h00);
		host.access(1'b1, 8'h4B, 8'h01);
		check({7'h00, reset_n}, 8'h00);
		rd(8'h4B, 8'h01);
		host.access(1'b1, 8'h4B, 8'h00);
		check({7'h00, reset_n}, 8'h00);
		rd(8'h4B, 8'h01);
		repeat (10) @(negedge clk_i);
		check({7'h00, reset_n}, 8'h01);
		rd(8'h4B, 8'h00);
		$display("test pulse done");
	endtask

	task automatic test_power_off();
		host.access(1'b1, 8'h4B, 8'h02);
		check({7'h00, off}, 8'h01);
		host.access(1'b1, 8'h4B, 8'h00);
		repeat (4) @(negedge clk_i);
		check({7'h00, off}, 8'h01);
		rd(8'h4B, 8'h02);
		do_reset();
		check({7'h00, off}, 8'h00);
		rd(8'h4B, 8'h00);
		$display("test power off done");
	endtask

	task automatic test_alert();
		for (int i = 0; i < 16; i++) begin
			live.external_overtemp_live = i[0];
			general_purpose_input = i[1];
			live.internal_overtemp_live = i[2];
			inv = i[3];
			repeat (3) @(negedge clk_i);
			rd(8'h4C, {5'h00, i[2], i[1] ^ i[3], i[0]});
		end
		host.access(1'b1, 8'h4C, 8'hFF);
		rd(8'h4C, {5'h00, 1'b1, 1'b0, 1'b1});
		$display("test alert done");
	endtask

	task automatic test_ramp();
		int per [4] = '{64, 16, 8, 4};
		logic [7:0] tgt;
		logic [7:0] prev;
		int n;
		host.access(1'b1, 8'hC1, 8'h5A);
		check(dac, 8'h5A);
		for (int r = 0; r < 4; r++) begin
			host.access(1'b1, 8'hC0, {5'h00, 2'(r), 1'b1});
			prev = dac;
			tgt = r[0] ? dac - 8'h03 : dac + 8'h03;
			host.access(1'b1, 8'hC1, tgt);
			check(dac, prev);
			rd(8'hC1, tgt);
			prev = dac;
			n = 0;
			while (dac === prev && n < 300) begin
				n++;
				@(negedge clk_i);
			end
			check(dac, r[0] ? prev - 8'h01 : prev + 8'h01);
			prev = dac;
			n = 0;
			while (dac === prev && n < 300) begin
				n++;
				@(negedge clk_i);
			end
			check(8'(n), 8'(per[r]));
			repeat (3 * per[r]) @(negedge clk_i);
			check(dac, tgt);
		end
		host.access(1'b1, 8'hC0, 8'h00);
		host.access(1'b1, 8'hC1, 8'h21);
		check(dac, 8'h21);
		$display("test ramp done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	initial begin
		do_reset();
		test_reset_values();
		test_pulse();
		test_power_off();
		test_alert();
		test_ramp();
		finish_test();
	end

endmodule // test_remote_ctrl_alert_fan_ramp
